// >>> isel_core.sv
// Added by the designer: the register offsets and the address-and-strobe port.
`default_nettype none
module isel_core (
  input wire logic clk,
  input wire logic nrst,
  input wire isel_pkg::isel_tc_t tc,
  input wire isel_pkg::isel_exec_t exec,
  input wire isel_pkg::isel_evt_t fault,
  input wire isel_pkg::isel_evt_t safety_evt,
  input wire logic [31:0] met_time,
  input wire logic safe_req,
  input wire logic safety_timeout,
  input wire logic hv_cmd,
  input wire logic heater_cmd,
  input wire logic act_cmd,
  input wire logic act_bus_pwr,
  input wire logic dump_allowed,
  input wire logic [15:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  output isel_pkg::isel_state_t op_state,
  output logic hv_on,
  output logic heater_en,
  output logic act_en,
  output logic door_close,
  output logic acq_hw_en,
  output logic safety_chk_en,
  output logic hk_tm_en,
  output logic sci_tm_en,
  output logic dump_tm_en,
  output logic [15:0] cnt_accepted,
  output logic [15:0] cnt_rejected,
  output logic [15:0] cnt_executed,
  output logic [7:0] last_fail_code,
  output logic [7:0] last_failed_command,
  output logic [7:0] last_safety
);

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  isel_pkg::isel_state_t state_r;
  isel_pkg::isel_state_t state_nxt;
  logic [2:0] pwr_sync_r;
  logic act_pwr_r;
  logic [2:0] ctrl_r;
  logic [7:0] cur_cmd_r;
  logic [15:0] acc_r;
  logic [15:0] rej_r;
  logic [15:0] exe_r;
  logic [7:0] fail_code_r;
  logic [7:0] fail_cmd_r;
  logic [7:0] safety_r;
  logic hv_r;
  logic heat_r;
  logic act_r;
  logic door_r;
  logic acqhw_r;
  logic schk_r;
  logic hk_r;
  logic sci_r;
  logic dump_r;
  logic [31:0] rdata_r;

  function automatic logic trans_ok(isel_pkg::isel_state_t cur,
                                    isel_pkg::isel_state_t tgt,
                                    logic blocked);
    trans_ok = (cur != isel_pkg::ST_SAFE) || (tgt == isel_pkg::ST_SAFE) ||
               !blocked;
  endfunction : trans_ok

  // --------------------------------------------------------------
  // command checking
  // --------------------------------------------------------------
  logic blocked_w;
  logic perm_w;
  logic trans_w;
  logic accept_w;
  logic reject_w;
  logic [7:0] rej_code_w;
  logic exec_fail_w;
  logic clr_w;
  logic err_w;
  logic log_wr_w;

  assign blocked_w = safety_timeout & ~ctrl_r[isel_pkg::CTRL_OVERRIDE];
  assign perm_w = |(tc.ok_states & state_r);
  assign trans_w = !tc.chg || trans_ok(state_r, tc.target, blocked_w);
  assign accept_w = tc.valid & tc.fmt_ok & perm_w & trans_w;
  assign reject_w = tc.valid & ~accept_w;
  assign rej_code_w = !tc.fmt_ok ? tc.err_code :
                      !perm_w ? isel_pkg::ERR_STATE :
                      isel_pkg::ERR_TRANSITION;
  assign exec_fail_w = exec.done & ~exec.ok;
  assign clr_w = accept_w & tc.clear;
  assign err_w = reject_w | exec_fail_w | fault.valid;
  assign log_wr_w = err_w | clr_w;

  // --------------------------------------------------------------
  // error fields
  // --------------------------------------------------------------
  logic [7:0] code_nxt;
  logic [7:0] cmd_nxt;

  assign code_nxt = reject_w ? rej_code_w :
                    exec_fail_w ? exec.code :
                    fault.valid ? fault.code :
                    clr_w ? isel_pkg::ERR_RESET : fail_code_r;
  assign cmd_nxt = reject_w ? tc.code[7:0] :
                   exec_fail_w ? cur_cmd_r :
                   fault.valid ? fail_cmd_r :
                   clr_w ? isel_pkg::NO_CMD : fail_cmd_r;

  // --------------------------------------------------------------
  // state transitions and outputs
  // --------------------------------------------------------------
  logic enter_safe_w;
  logic leave_safe_w;
  logic [7:0] safety_nxt;
  logic hv_nxt;

  assign state_nxt = (safe_req && state_r != isel_pkg::ST_SAFE) ?
                     isel_pkg::ST_SAFE :
                     (accept_w && tc.chg) ? tc.target : state_r;
  assign enter_safe_w = state_nxt == isel_pkg::ST_SAFE &&
                        state_r != isel_pkg::ST_SAFE;
  assign leave_safe_w = state_r == isel_pkg::ST_SAFE &&
                        state_nxt != isel_pkg::ST_SAFE;
  assign safety_nxt = safety_evt.valid ? safety_evt.code :
                      leave_safe_w ? isel_pkg::SAFETY_NONE : safety_r;
  assign hv_nxt = state_nxt == isel_pkg::ST_ACQ ||
                  (state_nxt == isel_pkg::ST_CHK && hv_cmd);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= isel_pkg::ST_SAFE;
      hv_r <= 1'b0;
      heat_r <= 1'b0;
      act_r <= 1'b0;
      door_r <= 1'b0;
      acqhw_r <= 1'b0;
      schk_r <= 1'b0;
      hk_r <= 1'b0;
      sci_r <= 1'b0;
      dump_r <= 1'b0;
      safety_r <= isel_pkg::SAFETY_NONE;
    end else begin
      state_r <= state_nxt;
      hv_r <= hv_nxt;
      heat_r <= state_nxt != isel_pkg::ST_SAFE && heater_cmd;
      act_r <= state_nxt != isel_pkg::ST_SAFE && act_cmd;
      door_r <= enter_safe_w && ctrl_r[isel_pkg::CTRL_DOOR_EN] &&
                act_pwr_r;
      acqhw_r <= state_nxt == isel_pkg::ST_ACQ;
      schk_r <= state_nxt == isel_pkg::ST_ACQ || hv_nxt;
      hk_r <= 1'b1;
      sci_r <= state_nxt == isel_pkg::ST_ACQ;
      dump_r <= state_nxt == isel_pkg::ST_CHK &&
                ctrl_r[isel_pkg::CTRL_DUMP_REQ] && dump_allowed;
      safety_r <= safety_nxt;
    end
  end

  // --------------------------------------------------------------
  // counters and error fields
  // --------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_r <= isel_pkg::CNT_RESET;
      rej_r <= isel_pkg::CNT_RESET;
      exe_r <= isel_pkg::CNT_RESET;
      cur_cmd_r <= isel_pkg::NO_CMD;
      fail_code_r <= isel_pkg::ERR_POWERUP;
      fail_cmd_r <= isel_pkg::NO_CMD;
    end else begin
      acc_r <= acc_r + {15'h0, accept_w};
      rej_r <= rej_r + {15'h0, reject_w};
      exe_r <= exe_r + {15'h0, exec.done & exec.ok};
      if (accept_w) begin
        cur_cmd_r <= tc.code[7:0];
      end
      fail_code_r <= code_nxt;
      fail_cmd_r <= cmd_nxt;
    end
  end

  // --------------------------------------------------------------
  // actuator bus power pin synchroniser
  // --------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwr_sync_r <= 3'h0;
      act_pwr_r <= 1'b0;
    end else begin
      pwr_sync_r <= {pwr_sync_r[1:0], act_bus_pwr};
      if (pwr_sync_r[1] == pwr_sync_r[2]) begin
        act_pwr_r <= pwr_sync_r[2];
      end
    end
  end

  // --------------------------------------------------------------
  // error log
  // --------------------------------------------------------------
  isel_pkg::isel_entry_t entry_w;
  logic [31:0] log_word_w;
  logic [2:0] log_ptr_w;

  assign entry_w = '{met_time, code_nxt, cmd_nxt, {5'h00, state_r},
                     safety_r, acc_r, rej_r, exe_r, 16'h0000};

  isel_log u_log (
    .clk(clk),
    .nrst(nrst),
    .wr(log_wr_w),
    .entry(entry_w),
    .rd_idx(bus_addr[6:2]),
    .rd_word(log_word_w),
    .ptr(log_ptr_w)
  );

  // --------------------------------------------------------------
  // register port
  // --------------------------------------------------------------
  logic in_log_w;
  logic [31:0] rd_mux_w;

  assign in_log_w = bus_addr[15:7] == isel_pkg::LOG_BASE[15:7];
  assign rd_mux_w =
    in_log_w ? log_word_w :
    bus_addr == isel_pkg::REG_STATE ? {21'h0, log_ptr_w, 5'h00,
                                       state_r} :
    bus_addr == isel_pkg::REG_CNT_AR ? {acc_r, rej_r} :
    bus_addr == isel_pkg::REG_CNT_EX ? {16'h0000, exe_r} :
    bus_addr == isel_pkg::REG_FAIL ? {16'h0000, fail_code_r, fail_cmd_r} :
    bus_addr == isel_pkg::REG_CTRL ? {29'h0, ctrl_r} :
    bus_addr == isel_pkg::REG_SAFETY ? {24'h000000, safety_r} :
    32'h00000000;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= isel_pkg::CTRL_RESET;
      rdata_r <= 32'h00000000;
    end else begin
      if (bus_wr && bus_addr == isel_pkg::REG_CTRL) begin
        ctrl_r <= bus_wdata[2:0];
      end
      rdata_r <= bus_rd ? rd_mux_w : 32'h00000000;
    end
  end

  assign bus_rdata = rdata_r;
  assign op_state = state_r;
  assign hv_on = hv_r;
  assign heater_en = heat_r;
  assign act_en = act_r;
  assign door_close = door_r;
  assign acq_hw_en = acqhw_r;
  assign safety_chk_en = schk_r;
  assign hk_tm_en = hk_r;
  assign sci_tm_en = sci_r;
  assign dump_tm_en = dump_r;
  assign cnt_accepted = acc_r;
  assign cnt_rejected = rej_r;
  assign cnt_executed = exe_r;
  assign last_fail_code = fail_code_r;
  assign last_failed_command = fail_cmd_r;
  assign last_safety = safety_r;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  logic [15:0] tot_w;
  assign tot_w = acc_r + rej_r;

  sequence s_enter_safe;
    state_r != isel_pkg::ST_SAFE ##1 state_r == isel_pkg::ST_SAFE;
  endsequence
  sequence s_leave_safe;
    state_r == isel_pkg::ST_SAFE ##1 state_r != isel_pkg::ST_SAFE;
  endsequence

  chk_safe_entry_off: assert property (s_enter_safe |->
      !hv_r && !heat_r && !act_r && door_r == $past(
      ctrl_r[isel_pkg::CTRL_DOOR_EN] && act_pwr_r))
    else $error("safe entry left a control active");
  chk_leave_safe_gate: assert property (s_leave_safe |->
      $past(!blocked_w) && (safety_r == isel_pkg::SAFETY_NONE ||
      $past(safety_evt.valid)))
    else $error("left safe while timeout active");
  chk_acq_outputs: assert property (state_r == isel_pkg::ST_ACQ |->
      hv_r && acqhw_r && schk_r && hk_r && sci_r)
    else $error("acquire outputs missing");
  chk_dump_gate: assert property (dump_r |->
      state_r == isel_pkg::ST_CHK && $past(dump_allowed))
    else $error("dump enabled without permission");
  chk_one_counter: assert property (tc.valid |=>
      tot_w == $past(tot_w) + 16'h0001)
    else $error("command counters not bumped once");
  chk_reject_error: assert property (reject_w |=>
      fail_code_r == $past(rej_code_w) &&
      fail_cmd_r == $past(tc.code[7:0]))
    else $error("rejection not reported");
  chk_fault_no_cmd: assert property (fault.valid && !reject_w &&
      !exec_fail_w |=> $stable(fail_cmd_r) && fail_code_r == $past(fault.code))
    else $error("unrelated error touched command byte");
  chk_clear_fields: assert property (clr_w && !err_w |-> log_wr_w
      ##1 fail_code_r == 8'hfd && fail_cmd_r == 8'hff)
    else $error("status clear not applied");
  chk_chk_to_acq: assert property (state_r == isel_pkg::ST_CHK &&
      accept_w && tc.chg && tc.target == isel_pkg::ST_ACQ && !safe_req
      |=> state_r == isel_pkg::ST_ACQ)
    else $error("checkout to acquire refused");

endmodule : isel_core
`default_nettype wire

// >>> isel_pkg.sv
`default_nettype none
package isel_pkg;

  // --------------------------------------------------------------
  // operational states
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_SAFE = 3'b001,
    ST_ACQ = 3'b010,
    ST_CHK = 3'b100
  } isel_state_t;

  // --------------------------------------------------------------
  // error codes and markers
  // --------------------------------------------------------------
  localparam logic [7:0] NO_CMD = 8'hff;
  localparam logic [7:0] ERR_POWERUP = 8'hfe;
  localparam logic [7:0] ERR_RESET = 8'hfd;
  localparam logic [7:0] ERR_NEXT_SLOT = 8'hf8;
  localparam logic [7:0] ERR_STATE = 8'h10;
  localparam logic [7:0] ERR_TRANSITION = 8'h11;
  localparam logic [7:0] SAFETY_NONE = 8'h00;
  localparam logic [31:0] LOG_FREE_TIME = 32'h46726565;

  // --------------------------------------------------------------
  // log geometry and register map (byte addresses)
  // --------------------------------------------------------------
  localparam int LOG_ENTRIES = 8;
  localparam int LOG_BYTES = 128;
  localparam int ENTRY_BYTES = 16;
  localparam logic [15:0] LOG_BASE = 16'h8200;
  localparam logic [15:0] REG_STATE = 16'h8000;
  localparam logic [15:0] REG_CNT_AR = 16'h8004;
  localparam logic [15:0] REG_CNT_EX = 16'h8008;
  localparam logic [15:0] REG_FAIL = 16'h800c;
  localparam logic [15:0] REG_CTRL = 16'h8010;
  localparam logic [15:0] REG_SAFETY = 16'h8014;
  localparam int CTRL_OVERRIDE = 0;
  localparam int CTRL_DOOR_EN = 1;
  localparam int CTRL_DUMP_REQ = 2;
  localparam logic [2:0] CTRL_RESET = 3'h2;
  localparam logic [15:0] CNT_RESET = 16'h0000;

  // --------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [15:0] code;
    logic fmt_ok;
    logic [7:0] err_code;
    logic [2:0] ok_states;
    logic chg;
    isel_state_t target;
    logic clear;
  } isel_tc_t;

  typedef struct packed {
    logic done;
    logic ok;
    logic [7:0] code;
  } isel_exec_t;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
  } isel_evt_t;

  // one 16-byte log entry, word 0 is the time
  typedef struct packed {
    logic [31:0] time_s;
    logic [7:0] code;
    logic [7:0] cmd;
    logic [7:0] state;
    logic [7:0] safety;
    logic [15:0] accepted;
    logic [15:0] rejected;
    logic [15:0] executed;
    logic [15:0] spare;
  } isel_entry_t;

  localparam isel_entry_t LOG_INIT_FREE = '{LOG_FREE_TIME, ERR_POWERUP,
    NO_CMD, 8'h00, 8'h00, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  localparam isel_entry_t LOG_INIT_NEXT = '{LOG_FREE_TIME, ERR_NEXT_SLOT,
    NO_CMD, 8'h00, 8'h00, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

endpackage : isel_pkg
`default_nettype wire

// >>> isel_log.sv
`default_nettype none
module isel_log (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wr,
  input wire isel_pkg::isel_entry_t entry,
  input wire logic [4:0] rd_idx,
  output logic [31:0] rd_word,
  output logic [2:0] ptr
);

  // --------------------------------------------------------------
  // storage
  // --------------------------------------------------------------
  isel_pkg::isel_entry_t mem [isel_pkg::LOG_ENTRIES];
  logic [2:0] ptr_r;
  logic [2:0] ptr_nxt;
  logic [127:0] rd_ent_w;

  assign ptr_nxt = ptr_r + 3'h1;
  assign ptr = ptr_r;
  assign rd_ent_w = mem[rd_idx[4:2]];
  assign rd_word = rd_ent_w[{~rd_idx[1:0], 5'h00} +: 32];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < isel_pkg::LOG_ENTRIES; i++) begin
        mem[i] <= (i == 0) ? isel_pkg::LOG_INIT_NEXT :
                             isel_pkg::LOG_INIT_FREE;
      end
      ptr_r <= 3'h0;
    end else if (wr) begin
      mem[ptr_r] <= entry;
      mem[ptr_nxt].code <= isel_pkg::ERR_NEXT_SLOT;
      ptr_r <= ptr_nxt;
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_ptr_wrap: assert property (wr && ptr_r == 3'h7 |=> ptr_r == 3'h0)
    else $error("log pointer did not wrap");
  chk_next_marker: assert property (wr |=> mem[ptr_r].code == 8'hf8)
    else $error("next slot not marked");
  chk_ptr_hold: assert property (!wr |=> $stable(ptr_r))
    else $error("log pointer moved without a write");

endmodule : isel_log
`default_nettype wire

// >>> isel_tcm.sv
`default_nettype none
module isel_tcm (
  input wire logic clk,
  output var isel_pkg::isel_tc_t tc,
  output var isel_pkg::isel_exec_t exec,
  output var isel_pkg::isel_evt_t fault,
  output var isel_pkg::isel_evt_t safety_evt
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // idle values
  // ------------------------------------------------------------
  initial begin
    tc = '0;
    exec = '0;
    fault = '0;
    safety_evt = '0;
  end

  // ------------------------------------------------------------
  // one-cycle requests from decoder and command handling
  // ------------------------------------------------------------
  task automatic cmd(input logic [15:0] code, input logic [2:0] oks,
      input logic chg, input isel_pkg::isel_state_t tgt, input logic clr,
      input logic fok, input logic [7:0] ec);
    @(posedge clk);
    tc <= '{1'b1, code, fok, ec, oks, chg, tgt, clr};
    @(posedge clk);
    tc <= '0;
  endtask : cmd

  task automatic done(input logic ok, input logic [7:0] code);
    @(posedge clk);
    exec <= '{1'b1, ok, code};
    @(posedge clk);
    exec <= '0;
  endtask : done

  task automatic evt(input logic sel, input logic [7:0] code);
    @(posedge clk);
    if (sel) safety_evt <= '{1'b1, code};
    else fault <= '{1'b1, code};
    @(posedge clk);
    safety_evt <= '0;
    fault <= '0;
  endtask : evt
endmodule : isel_tcm
`default_nettype wire

// >>> tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, safe_req, safety_timeout, hv_cmd, heater_cmd, act_cmd;
  logic act_bus_pwr, dump_allowed, bus_wr, bus_rd;
  logic [31:0] met_time, bus_wdata, bus_rdata, d;
  logic [15:0] bus_addr, cnt_accepted, cnt_rejected, cnt_executed;
  logic [7:0] last_fail_code, last_failed_command, last_safety;
  logic hv_on, heater_en, act_en, door_close, acq_hw_en, safety_chk_en;
  logic hk_tm_en, sci_tm_en, dump_tm_en;
  isel_pkg::isel_state_t op_state;
  isel_pkg::isel_tc_t tc;
  isel_pkg::isel_exec_t exec;
  isel_pkg::isel_evt_t fault, safety_evt;
  int errors = 0;
  int checks = 0;
  bit door_seen = 0;

  isel_tcm u_isel_tcm (.clk(clk), .tc(tc), .exec(exec), .fault(fault),
    .safety_evt(safety_evt));
  isel_core u_isel_core (.clk(clk), .nrst(nrst), .tc(tc), .exec(exec),
    .fault(fault), .safety_evt(safety_evt), .met_time(met_time),
    .safe_req(safe_req), .safety_timeout(safety_timeout), .hv_cmd(hv_cmd),
    .heater_cmd(heater_cmd), .act_cmd(act_cmd), .act_bus_pwr(act_bus_pwr),
    .dump_allowed(dump_allowed), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .op_state(op_state), .hv_on(hv_on), .heater_en(heater_en),
    .act_en(act_en), .door_close(door_close), .acq_hw_en(acq_hw_en),
    .safety_chk_en(safety_chk_en), .hk_tm_en(hk_tm_en),
    .sci_tm_en(sci_tm_en), .dump_tm_en(dump_tm_en),
    .cnt_accepted(cnt_accepted), .cnt_rejected(cnt_rejected),
    .cnt_executed(cnt_executed), .last_fail_code(last_fail_code),
    .last_failed_command(last_failed_command), .last_safety(last_safety));

  // ------------------------------------------------------------
  // clock, door pulse monitor, watchdog
  // ------------------------------------------------------------
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) if (door_close === 1'b1) door_seen = 1;

  initial begin
    #100us;
    errors++;
    results();
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    @(posedge clk);
    bus_wr <= 1;
    bus_addr <= a;
    bus_wdata <= v;
    @(posedge clk);
    bus_wr <= 0;
  endtask : wr

  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    bus_rd <= 1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 0;
    #1;
    d = bus_rdata;
  endtask : rd

  // code byte of log entry e
  task automatic logc(input int e, input logic [7:0] exp);
    rd(isel_pkg::LOG_BASE + 16'(16 * e + 4));
    chk(d[31:24], exp);
  endtask : logc

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  task automatic fails(input logic [7:0] c, input logic [7:0] b);
    chk(last_fail_code, c);
    chk(last_failed_command, b);
  endtask : fails

  task automatic results();
    if (errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    {nrst, safe_req, safety_timeout, hv_cmd, heater_cmd, act_cmd} = '0;
    {dump_allowed, bus_wr, bus_rd, bus_addr, bus_wdata} = '0;
    act_bus_pwr = 1;
    met_time = 32'h0000abcd;
    repeat (20) @(posedge clk);
    nrst <= 1;
    settle();
    fails(8'hfe, 8'hff);
    chk(op_state, isel_pkg::ST_SAFE);
    rd(isel_pkg::LOG_BASE + 16'h0010);
    chk(d, 32'h46726565);
    logc(0, 8'hf8);
    logc(1, 8'hfe);
    // command not allowed in safe
    u_isel_tcm.cmd(16'h0131, 3'b100, 0, isel_pkg::ST_SAFE, 0, 1, 0);
    settle();
    fails(8'h10, 8'h31);
    chk(cnt_rejected, 16'h0001);
    rd(isel_pkg::LOG_BASE);
    chk(d, 32'h0000abcd);
    logc(0, 8'h10);
    logc(1, 8'hf8);
    // decoder format error
    u_isel_tcm.cmd(16'h0242, 3'b111, 0, isel_pkg::ST_SAFE, 0, 0, 8'h33);
    settle();
    fails(8'h33, 8'h42);
    // leave safe blocked by timeout, then override
    u_isel_tcm.evt(1, 8'h5a);
    safety_timeout <= 1;
    u_isel_tcm.cmd(16'h1222, 3'b001, 1, isel_pkg::ST_CHK, 0, 1, 0);
    settle();
    chk(op_state, isel_pkg::ST_SAFE);
    fails(8'h11, 8'h22);
    chk(last_safety, 8'h5a);
    wr(isel_pkg::REG_CTRL, 32'h3);
    u_isel_tcm.cmd(16'h1222, 3'b001, 1, isel_pkg::ST_CHK, 0, 1, 0);
    settle();
    chk(op_state, isel_pkg::ST_CHK);
    chk(last_safety, 8'h00);
    chk({hk_tm_en, dump_tm_en}, 2'b10);
    @(posedge clk);
    dump_allowed <= 1;
    wr(isel_pkg::REG_CTRL, 32'h7);
    settle();
    chk(dump_tm_en, 1'b1);
    // checkout to acquire and back
    u_isel_tcm.cmd(16'h1233, 3'b100, 1, isel_pkg::ST_ACQ, 0, 1, 0);
    settle();
    chk(op_state, isel_pkg::ST_ACQ);
    chk({hv_on, safety_chk_en, acq_hw_en, hk_tm_en, sci_tm_en}, 5'h1f);
    u_isel_tcm.cmd(16'h1244, 3'b010, 1, isel_pkg::ST_CHK, 0, 1, 0);
    settle();
    chk(op_state, isel_pkg::ST_CHK);
    chk(sci_tm_en, 1'b0);
    // execution results and faults
    u_isel_tcm.done(1, 8'h00);
    settle();
    chk(cnt_executed, 16'h0001);
    u_isel_tcm.done(0, 8'h55);
    settle();
    fails(8'h55, 8'h44);
    u_isel_tcm.evt(0, 8'h66);
    settle();
    fails(8'h66, 8'h44);
    u_isel_tcm.evt(0, 8'h77);
    u_isel_tcm.evt(0, 8'h78);
    settle();
    chk(last_fail_code, 8'h78);
    rd(isel_pkg::REG_STATE);
    chk(d[10:8], 3'h7);
    // safe entry from acquire
    u_isel_tcm.cmd(16'h1233, 3'b100, 1, isel_pkg::ST_ACQ, 0, 1, 0);
    {hv_cmd, heater_cmd, act_cmd} <= 3'b111;
    settle();
    chk({heater_en, act_en}, 2'b11);
    door_seen = 0;
    @(posedge clk);
    safe_req <= 1;
    @(posedge clk);
    safe_req <= 0;
    settle();
    chk(op_state, isel_pkg::ST_SAFE);
    chk({hv_on, heater_en, act_en}, 3'b000);
    chk(door_seen, 1'b1);
    // status clear appends an entry, pointer wraps
    u_isel_tcm.cmd(16'h0399, 3'b111, 0, isel_pkg::ST_SAFE, 1, 1, 0);
    settle();
    fails(8'hfd, 8'hff);
    logc(7, 8'hfd);
    logc(0, 8'hf8);
    logc(1, 8'h33);
    rd(isel_pkg::REG_STATE);
    chk(d[10:8], 3'h0);
    // counters, ignored write, unmapped read
    wr(isel_pkg::REG_CNT_AR, 32'hffffffff);
    rd(isel_pkg::REG_CNT_AR);
    chk(d, 32'h00050003);
    rd(16'h8040);
    chk(d, 32'h0);
    results();
  end
endmodule : tb
`default_nettype wire
